// ---- verilog/bmss_pkg.sv ----
// bmss_pkg: constants and types for the battery monitor serial/status block
// assumes a 40 MHz internal clock and a level/flag feed from the charger core
package bmss_pkg;

  // ==========================================
  // clock and timing
  localparam int unsigned BMSS_CLK_NS = 25;
  localparam int unsigned BMSS_MS_NS = 1000000;
  localparam int unsigned BMSS_PULSE_LONG_MS = 300;
  localparam int unsigned BMSS_PULSE_SHORT_MS = 100;
  localparam int unsigned BMSS_PULSE_GAP_MS = 200;
  localparam int unsigned BMSS_REPEAT_MS = 1000;

  // ==========================================
  // serial port framing and map
  localparam logic [3:0] BMSS_ADDR_BITS = 4'h8;
  localparam logic [7:0] BMSS_ADDR_VBAT = 8'h6e;
  localparam logic [7:0] BMSS_ADDR_STAT_HI = 8'h69;
  localparam logic [7:0] BMSS_ADDR_STAT_LO = 8'h68;
  localparam logic [7:0] BMSS_RESERVED_DATA = 8'h00;

  // ==========================================
  // charger status word bit positions
  localparam int unsigned BMSS_BIT_EOC = 8;
  localparam int unsigned BMSS_BIT_SLOW = 7;
  localparam int unsigned BMSS_BIT_DRAIN = 6;
  localparam int unsigned BMSS_BIT_TIMER = 2;
  localparam int unsigned BMSS_BIT_DIR = 1;
  localparam int unsigned BMSS_BIT_UVOK = 0;

  // ==========================================
  // level code thresholds, code * 0.03 V
  localparam logic [7:0] BMSS_LVL_VERY_LOW = 8'h64;
  localparam logic [7:0] BMSS_LVL_20 = 8'h72;
  localparam logic [7:0] BMSS_LVL_40 = 8'h78;
  localparam logic [7:0] BMSS_LVL_60 = 8'h7e;
  localparam logic [7:0] BMSS_LVL_80 = 8'h84;

  // ==========================================
  // types
  typedef struct packed {
    logic end_of_charge;
    logic slow_phase_flag;
    logic draining_flag;
    logic timer_running;
    logic charge_direction_flag;
    logic undervoltage_ok_flag;
  } bmss_status_t;

  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_ADDR = 3'b010,
    SP_DATA = 3'b100
  } bmss_sp_state_t;

  typedef enum logic [3:0] {
    IND_IDLE = 4'b0001,
    IND_PULSE = 4'b0010,
    IND_GAP = 4'b0100,
    IND_WAIT = 4'b1000
  } bmss_ind_state_t;

endpackage

// ---- verilog/bmss_top.sv ----
// bmss_top: serial readout port and push-button level indicator
// assumes rst_n is the on-chip power-on reset and clk the on-chip oscillator;
// level code and charger flags come from core logic on the same clock
// Behaviour
// - transaction starts on select rising edge
// - address bits sampled on clock rising edge
// - first data bit on next falling edge
// - byte returned LSB first, bit per cycle
// - bits after the eighth are undefined
// - 6Eh level, 69h status high, 68h low
// - level code times 0.03 V is voltage
// - status word 16 bits, reserved bits zero
// - bits 8 eoc, 7 slow, 6 draining
// - bits 2 timer, 1 direction, 0 ok
// - button press starts 300 ms pulses
// - pulse count encodes battery level band
// - very low level gives one 100 ms pulse
// - sequence repeats every second while pressed
// - on-chip power-on reset, no reset pin
// - internal clock divided down to save power; logic here runs on undivided clk, with only a ms tick enable
`timescale 1ns/1ps
`default_nettype none

module bmss_top
  import bmss_pkg::*;
#(
  parameter int unsigned MS_DIV = BMSS_MS_NS / BMSS_CLK_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic select_line,
  input wire logic serial_addr_in,
  output logic serial_data_out,
  input wire logic level_indicator_in,
  output logic level_indicator_out,
  output logic level_indicator_oe,
  input wire logic [7:0] battery_level_code,
  input wire bmss_status_t charger_status
);

  // ==========================================
  // register contents
  logic [15:0] status_word;

  always_comb begin
    status_word = 16'h0000;
    status_word[BMSS_BIT_EOC] = charger_status.end_of_charge;
    status_word[BMSS_BIT_SLOW] = charger_status.slow_phase_flag;
    status_word[BMSS_BIT_DRAIN] = charger_status.draining_flag;
    status_word[BMSS_BIT_TIMER] = charger_status.timer_running;
    status_word[BMSS_BIT_DIR] = charger_status.charge_direction_flag;
    status_word[BMSS_BIT_UVOK] = charger_status.undervoltage_ok_flag;
  end

  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    unique case (addr)
      BMSS_ADDR_VBAT: read_reg = battery_level_code;
      BMSS_ADDR_STAT_HI: read_reg = status_word[15:8];
      BMSS_ADDR_STAT_LO: read_reg = status_word[7:0];
      default: read_reg = BMSS_RESERVED_DATA;
    endcase
  endfunction

  // ==========================================
  // pin synchronisers
  logic [1:0] sck_sync_r;
  logic [1:0] sel_sync_r;
  logic [1:0] serial_addr_in_sync_r;
  logic [1:0] btn_sync_r;
  logic sck_prev_r;
  logic sel_prev_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_sync_r <= 2'h0;
      sel_sync_r <= 2'h0;
      serial_addr_in_sync_r <= 2'h0;
      btn_sync_r <= 2'h0;
      sck_prev_r <= 1'b0;
      sel_prev_r <= 1'b0;
    end else begin
      sck_sync_r <= {sck_sync_r[0], sck};
      sel_sync_r <= {sel_sync_r[0], select_line};
      serial_addr_in_sync_r <= {serial_addr_in_sync_r[0], serial_addr_in};
      btn_sync_r <= {btn_sync_r[0], ~level_indicator_in};
      sck_prev_r <= sck_sync_r[1];
      sel_prev_r <= sel_sync_r[1];
    end
  end

  logic sck_s;
  logic sel_s;
  logic serial_addr_in_s;
  logic btn_s;
  logic sck_rise;
  logic sck_fall;
  logic sel_rise;

  assign sck_s = sck_sync_r[1];
  assign sel_s = sel_sync_r[1];
  assign serial_addr_in_s = serial_addr_in_sync_r[1];
  assign btn_s = btn_sync_r[1];
  assign sck_rise = sck_s & ~sck_prev_r;
  assign sck_fall = ~sck_s & sck_prev_r;
  assign sel_rise = sel_s & ~sel_prev_r;

  // ==========================================
  // serial port
  bmss_sp_state_t sp_state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] addr_r;
  logic [7:0] shift_r;
  logic [7:0] next_addr;
  logic [7:0] cap_val;
  logic shift_lsb;

  assign next_addr = {serial_addr_in_s, addr_r[7:1]};
  assign cap_val = read_reg(next_addr);
  assign shift_lsb = shift_r[0];

  // select low aborts anything; relies on host parking pins low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp_state_r <= SP_IDLE;
      bit_cnt_r <= 3'h0;
      addr_r <= 8'h00;
    end else if (!sel_s) begin
      sp_state_r <= SP_IDLE;
      bit_cnt_r <= 3'h0;
    end else begin
      unique case (sp_state_r)
        SP_IDLE: begin
          if (sel_rise) begin
            sp_state_r <= SP_ADDR;
            bit_cnt_r <= 3'h0;
          end
        end
        SP_ADDR: begin
          if (sck_rise) begin
            addr_r <= next_addr;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'(BMSS_ADDR_BITS - 4'h1)) begin
              sp_state_r <= SP_DATA;
            end
          end
        end
        SP_DATA: begin
          // address input ignored until select drops
          sp_state_r <= SP_DATA;
        end
        default: begin
          sp_state_r <= SP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_r <= 8'h00;
    end else if (sp_state_r == SP_ADDR && sck_rise &&
                 bit_cnt_r == 3'(BMSS_ADDR_BITS - 4'h1) && sel_s) begin
      shift_r <= cap_val;
    end else if (sp_state_r == SP_DATA && sck_fall) begin
      // zero fill: bits past the eighth are don't-care for the host
      shift_r <= {1'b0, shift_r[7:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_data_out <= 1'b0;
    end else if (sp_state_r != SP_DATA || !sel_s) begin
      serial_data_out <= 1'b0;
    end else if (sck_fall) begin
      serial_data_out <= shift_lsb;
    end
  end

  // ==========================================
  // millisecond tick
  // ms grain keeps the indicator counters narrow
  logic [15:0] pre_cnt_r;
  logic ms_tick;

  assign ms_tick = (pre_cnt_r == 16'(MS_DIV - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_cnt_r <= 16'h0000;
    end else if (ms_tick) begin
      pre_cnt_r <= 16'h0000;
    end else begin
      pre_cnt_r <= pre_cnt_r + 16'h0001;
    end
  end

  // ==========================================
  // level indicator
  function automatic logic [2:0] level_pulses(input logic [7:0] code);
    if (code < BMSS_LVL_VERY_LOW) begin
      level_pulses = 3'h0;
    end else if (code < BMSS_LVL_20) begin
      level_pulses = 3'h1;
    end else if (code < BMSS_LVL_40) begin
      level_pulses = 3'h2;
    end else if (code < BMSS_LVL_60) begin
      level_pulses = 3'h3;
    end else if (code < BMSS_LVL_80) begin
      level_pulses = 3'h4;
    end else begin
      level_pulses = 3'h5;
    end
  endfunction

  bmss_ind_state_t ind_state_r;
  logic [9:0] ms_cnt_r;
  logic [2:0] pulses_left_r;
  logic half_r;
  logic [2:0] lvl_now;
  logic [9:0] pulse_len;
  logic ms_done;

  assign lvl_now = level_pulses(battery_level_code);
  assign pulse_len = half_r ? 10'(BMSS_PULSE_SHORT_MS) : 10'(BMSS_PULSE_LONG_MS);
  // end of the current interval only; a zero count is a fresh start, not an end
  assign ms_done = ms_tick && (
                   (ind_state_r == IND_PULSE && ms_cnt_r == pulse_len - 10'h001) ||
                   (ind_state_r == IND_GAP && ms_cnt_r == 10'(BMSS_PULSE_GAP_MS - 1)) ||
                   (ind_state_r == IND_WAIT && ms_cnt_r == 10'(BMSS_REPEAT_MS - 1)));

  // button seen only while the pin is released
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ind_state_r <= IND_IDLE;
      ms_cnt_r <= 10'h000;
      pulses_left_r <= 3'h0;
      half_r <= 1'b0;
    end else begin
      unique case (ind_state_r)
        IND_IDLE: begin
          ms_cnt_r <= 10'h000;
          if (btn_s) begin
            ind_state_r <= IND_PULSE;
            half_r <= (lvl_now == 3'h0);
            pulses_left_r <= (lvl_now == 3'h0) ? 3'h1 : lvl_now;
          end
        end
        IND_PULSE: begin
          if (ms_tick) begin
            ms_cnt_r <= ms_cnt_r + 10'h001;
          end
          if (ms_tick && ms_cnt_r == pulse_len - 10'h001) begin
            ms_cnt_r <= 10'h000;
            pulses_left_r <= pulses_left_r - 3'h1;
            ind_state_r <= (pulses_left_r > 3'h1) ? IND_GAP : IND_WAIT;
          end
        end
        IND_GAP: begin
          if (ms_tick) begin
            ms_cnt_r <= ms_cnt_r + 10'h001;
          end
          if (ms_tick && ms_cnt_r == 10'(BMSS_PULSE_GAP_MS - 1)) begin
            ms_cnt_r <= 10'h000;
            ind_state_r <= IND_PULSE;
          end
        end
        IND_WAIT: begin
          if (ms_tick) begin
            ms_cnt_r <= ms_cnt_r + 10'h001;
          end
          if (ms_tick && ms_cnt_r == 10'(BMSS_REPEAT_MS - 1)) begin
            ms_cnt_r <= 10'h000;
            ind_state_r <= IND_IDLE;
          end
        end
        default: begin
          ind_state_r <= IND_IDLE;
        end
      endcase
    end
  end

  assign level_indicator_oe = (ind_state_r == IND_PULSE);
  assign level_indicator_out = 1'b0;

  // ==========================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_last_addr_bit;
    sp_state_r == SP_ADDR && sel_s && sck_rise && bit_cnt_r == 3'h7;
  endsequence

  sequence s_data_fall;
    sp_state_r == SP_DATA && sel_s && sck_fall;
  endsequence

  a_start_on_rise: assert property (
    sp_state_r == SP_IDLE ##1 sp_state_r == SP_ADDR |-> $past(sel_rise))
    else $error("address phase entered without select rising");

  a_addr_sampled: assert property (
    sp_state_r == SP_ADDR && sel_s && sck_rise |=> addr_r[7] == $past(serial_addr_in_s))
    else $error("address bit not taken on clock rise");

  a_capture_value: assert property (
    s_last_addr_bit |=> shift_r == $past(cap_val) && sp_state_r == SP_DATA)
    else $error("addressed value not captured");

  a_first_bit_out: assert property (
    s_data_fall |=> serial_data_out == $past(shift_lsb))
    else $error("data bit not driven on clock fall");

  a_out_held: assert property (
    sp_state_r == SP_DATA && sel_s && !sck_fall ##1 sel_s |-> $stable(serial_data_out))
    else $error("data output moved without clock fall");

  a_sel_low_idle: assert property (
    !sel_s |=> sp_state_r == SP_IDLE ##1 serial_data_out == 1'b0)
    else $error("port not idle after select low");

  a_map_vbat: assert property (
    s_last_addr_bit ##0 next_addr == BMSS_ADDR_VBAT |=>
      shift_r == $past(battery_level_code))
    else $error("level register not mapped");

  a_reserved_zero: assert property (
    status_word[15:9] == 7'h00 && status_word[5:3] == 3'h0)
    else $error("reserved status bits not zero");

  a_pulse_bound: assert property (
    level_indicator_oe |-> ms_cnt_r < pulse_len && !level_indicator_out)
    else $error("indicator pulse overran its length");

  a_half_pulse: assert property (
    ind_state_r == IND_IDLE && btn_s && lvl_now == 3'h0 |=>
      half_r && pulses_left_r == 3'h1 && pulse_len == 10'(BMSS_PULSE_SHORT_MS))
    else $error("very low level did not start half pulse");

  a_repeat_gap: assert property (
    ind_state_r == IND_WAIT && ms_done |=> ind_state_r == IND_IDLE)
    else $error("repeat interval not honoured");

endmodule

`default_nettype wire

// ---- dv/bmss_host_model.sv ----
// bmss_host_model: host controller and push-button on the far side of the block
// assumes clk is the device clock; every pin change is launched just after its rising edge
`timescale 1ns/1ps
`default_nettype none

module bmss_host_model #(
  parameter int HALF = 20,
  parameter int GAP = 400
) (
  input wire logic clk,
  input wire logic serial_data_out,
  output logic sck,
  output logic select_line,
  output logic serial_addr_in,
  output logic button_n
);
  // ==========================================
  // idle levels
  initial begin
    sck = 1'b0;
    select_line = 1'b0;
    serial_addr_in = 1'b0;
    button_n = 1'b1;
  end

  // ==========================================
  // pin tasks, entered just after a clk edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic press(input logic down);
    button_n <= ~down;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    int i;
    select_line <= 1'b1;
    for (i = 0; i < 8; i++) begin
      serial_addr_in <= addr[i];
      wait_clk(HALF);
      sck <= 1'b1;
      wait_clk(HALF);
      sck <= 1'b0;
    end
    serial_addr_in <= 1'b0;
    for (i = 0; i < 8; i++) begin
      wait_clk(HALF);
      sck <= 1'b1;
      // bit settled since the previous fall
      data[i] = serial_data_out;
      wait_clk(HALF);
      sck <= 1'b0;
    end
    wait_clk(HALF);
    select_line <= 1'b0;
    wait_clk(GAP);
  endtask
endmodule
`default_nettype wire

// ---- dv/battery_monitor_serial_status_tb_top.sv ----
// battery_monitor_serial_status_tb_top: self-checking bench for bmss_top
// assumes the host model drives serial pins and button; ms tick shortened to MSD clocks
`timescale 1ns/1ps
`default_nettype none

module battery_monitor_serial_status_tb_top;
  import bmss_pkg::*;
  localparam int MSD = 5;
  typedef struct packed {
    logic [7:0] lvl;
    logic [5:0] st;
    logic [7:0] addr;
    logic [7:0] exp;
  } bmss_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sck, select_line, serial_addr_in, serial_data_out, button_n;
  logic level_indicator_in, level_indicator_out, level_indicator_oe;
  logic [7:0] battery_level_code = 8'h7a;
  bmss_status_t charger_status = '0;
  logic [7:0] d;
  int errors = 0;
  int check_count = 0;
  bmss_row_t rows [7] = '{
    '{8'hff, 6'h2d, 8'h6e, 8'hff}, '{8'h7a, 6'h2d, 8'h69, 8'h01},
    '{8'h7a, 6'h2d, 8'h68, 8'h45}, '{8'h7a, 6'h12, 8'h69, 8'h00},
    '{8'h7a, 6'h12, 8'h68, 8'h82}, '{8'h00, 6'h12, 8'h6e, 8'h00},
    '{8'h55, 6'h2d, 8'h6e, 8'h55}};

  always #12.5 clk = ~clk;
  // pull-up on the status pin; button or device drive pulls it low
  assign level_indicator_in = button_n & ~(level_indicator_oe & ~level_indicator_out);

  bmss_top #(.MS_DIV(MSD)) uut (.clk(clk), .rst_n(rst_n), .sck(sck),
    .select_line(select_line), .serial_addr_in(serial_addr_in),
    .serial_data_out(serial_data_out), .level_indicator_in(level_indicator_in),
    .level_indicator_out(level_indicator_out), .level_indicator_oe(level_indicator_oe),
    .battery_level_code(battery_level_code), .charger_status(charger_status));

  bmss_host_model #(.HALF(20), .GAP(400)) host (.clk(clk), .serial_data_out(serial_data_out),
    .sck(sck), .select_line(select_line), .serial_addr_in(serial_addr_in),
    .button_n(button_n));

  // ==========================================
  // checking and verdict
  task automatic fail_if(input logic bad, input string what);
    check_count++;
    if (bad !== 1'b0) begin
      errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================
  // one indicator readout: pulse count and widths, optional held button
  task automatic readout(input logic [7:0] code, input int n_exp, input int w_ms, input bit hold);
    int n, w, low;
    battery_level_code <= code;
    @(posedge clk);
    host.press(1'b1);
    for (low = 0; low < 100; low++) begin
      @(posedge clk);
      if (level_indicator_oe === 1'b1) break;
    end
    fail_if(low > 5, "readout start");
    if (!hold) host.press(1'b0);
    n = 0;
    w = 1;
    low = 0;
    while (low < 250 * MSD && n < 8) begin
      @(posedge clk);
      if (level_indicator_oe === 1'b1) begin
        w++;
        low = 0;
      end else begin
        if (w > 0) begin
          fail_if(w < (w_ms - 3) * MSD || w > w_ms * MSD + 1, "pulse width");
          n++;
        end
        w = 0;
        low++;
      end
    end
    fail_if(n != n_exp, "pulse count");
    if (hold) begin
      while (level_indicator_oe !== 1'b1 && low < 2400 * MSD) begin
        @(posedge clk);
        low++;
      end
      fail_if(low < 997 * MSD || low > 1001 * MSD, "repeat spacing");
      host.press(1'b0);
      repeat (1600 * MSD) @(posedge clk);
    end else begin
      repeat (800 * MSD) @(posedge clk);
    end
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    fail_if(serial_data_out !== 1'b0 || level_indicator_oe !== 1'b0, "reset outputs");
    fail_if(level_indicator_out !== 1'b0, "pin drive level");
    foreach (rows[i]) begin
      battery_level_code <= rows[i].lvl;
      charger_status <= bmss_status_t'(rows[i].st);
      @(posedge clk);
      host.read_reg(rows[i].addr, d);
      fail_if(d !== rows[i].exp, "register read");
    end
    // status changes in mid data phase must not tear the byte
    charger_status <= bmss_status_t'(6'h2d);
    @(posedge clk);
    fork
      host.read_reg(8'h68, d);
      begin
        repeat (400) @(posedge clk);
        charger_status <= bmss_status_t'(6'h12);
      end
    join
    fail_if(d !== 8'h45, "captured byte");
    readout(8'h63, 1, 100, 1'b1);
    readout(8'h64, 1, 300, 1'b0);
    readout(8'h77, 2, 300, 1'b0);
    readout(8'h7d, 3, 300, 1'b0);
    readout(8'h83, 4, 300, 1'b0);
    readout(8'h84, 5, 300, 1'b0);
    print_verdict();
  end

  // ==========================================
  // watchdog, some 14k cycles beyond the expected run length of about 81k
  initial begin
    repeat (95000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
